/* File: verilog/flash_host_pkg.sv */
`default_nettype none
package flash_host_pkg;

  // ****************************************
  // clock and pin timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int T_SETUP_NS = 20;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACCESS_NS = 85;
  localparam int T_WAKE_WRITE_NS = 1000;
  localparam int T_WAKE_READ_NS = 400;

  // least times, rounded up to whole cycles
  function automatic logic [8:0] ns_to_cyc(input int ns);
    return 9'((ns * CLK_MHZ + 999) / 1000);
  endfunction : ns_to_cyc

  localparam logic [8:0] CYC_SETUP = ns_to_cyc(T_SETUP_NS);
  localparam logic [8:0] CYC_WE_PULSE = ns_to_cyc(T_WE_PULSE_NS);
  localparam logic [8:0] CYC_HOLD = ns_to_cyc(T_HOLD_NS);
  localparam logic [8:0] CYC_ACCESS = ns_to_cyc(T_ACCESS_NS);
  localparam logic [8:0] CYC_SYNC = 9'h002;
  localparam logic [8:0] CYC_WAKE_WRITE = ns_to_cyc(T_WAKE_WRITE_NS);
  localparam logic [8:0] CYC_WAKE_READ = ns_to_cyc(T_WAKE_READ_NS);

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam int CFG_PD_BIT = 0;
  localparam int CFG_SUPPLY_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_AWAKE_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;

  localparam logic RST_PD = 1'b0;
  localparam logic RST_SUPPLY = 1'b0;
  localparam logic [19:0] RST_ADDR = 20'h00000;
  localparam logic [7:0] RST_WDATA = 8'h00;

  // ****************************************
  // operations and device command codes
  // ****************************************
  localparam logic [3:0] OP_READ_ARRAY = 4'h0;
  localparam logic [3:0] OP_READ_ID = 4'h1;
  localparam logic [3:0] OP_READ_STATUS = 4'h2;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
  localparam logic [3:0] OP_ERASE = 4'h4;
  localparam logic [3:0] OP_SUSPEND = 4'h5;
  localparam logic [3:0] OP_RESUME = 4'h6;
  localparam logic [3:0] OP_BYTE_WRITE = 4'h7;
  localparam logic [3:0] OP_ALT_WRITE = 4'h8;
  localparam logic [3:0] OP_PLAIN_READ = 4'h9;

  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_ALT_WRITE_SETUP = 8'h10;

  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;

  function automatic logic op_legal(input logic [3:0] op);
    return op <= OP_PLAIN_READ;
  endfunction : op_legal

  function automatic logic needs_cmd(input logic [3:0] op);
    return op != OP_PLAIN_READ;
  endfunction : needs_cmd

  function automatic logic [7:0] first_code(input logic [3:0] op);
    case (op)
      OP_READ_ID: return CMD_READ_ID;
      OP_READ_STATUS: return CMD_READ_STATUS;
      OP_CLEAR_STATUS: return CMD_CLEAR_STATUS;
      OP_ERASE: return CMD_ERASE_SETUP;
      OP_SUSPEND: return CMD_SUSPEND;
      OP_RESUME: return CMD_CONFIRM;
      OP_BYTE_WRITE: return CMD_WRITE_SETUP;
      OP_ALT_WRITE: return CMD_ALT_WRITE_SETUP;
      default: return CMD_READ_ARRAY;
    endcase
  endfunction : first_code

  function automatic logic [1:0] second_kind(input logic [3:0] op);
    case (op)
      OP_READ_ID, OP_READ_STATUS, OP_PLAIN_READ: return KIND_READ;
      OP_ERASE, OP_BYTE_WRITE, OP_ALT_WRITE: return KIND_WRITE;
      default: return KIND_NONE;
    endcase
  endfunction : second_kind

  function automatic logic [7:0] second_data(input logic [3:0] op, input logic [7:0] wd);
    return (op == OP_ERASE) ? CMD_CONFIRM : wd;
  endfunction : second_data

endpackage : flash_host_pkg
`default_nettype wire

/* File: verilog/flash_bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_read,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe_n,
  input wire logic [7:0] data_pins_in
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_ACCESS} cyc_state_t;

  cyc_state_t st_ff;
  cyc_state_t nxt_st;
  logic [8:0] cnt_ff;
  logic [8:0] nxt_cnt;
  logic [8:0] limit;
  logic [7:0] din_meta_ff;
  logic [7:0] din_sync_ff;
  logic last;
  logic go_new;
  logic [19:0] addr_ff;
  logic [7:0] dout_ff;
  logic ce_n_ff;
  logic oe_n_ff;
  logic we_n_ff;
  logic doe_n_ff;
  logic [7:0] rdata_ff;

  // ****************************************
  // phase length and sequencing
  // ****************************************
  // a read waits the access time plus the two synchroniser stages
  assign limit = (st_ff == E_SETUP) ? flash_host_pkg::CYC_SETUP :
                 (st_ff == E_STROBE) ? flash_host_pkg::CYC_WE_PULSE :
                 (st_ff == E_HOLD) ? flash_host_pkg::CYC_HOLD :
                 9'(flash_host_pkg::CYC_ACCESS + flash_host_pkg::CYC_SYNC);
  assign last = (cnt_ff == 9'(limit - 9'h001));
  assign done = last && (st_ff == E_HOLD || st_ff == E_ACCESS);
  // a new cycle may chain on the last cycle of the previous one
  assign go_new = start && (st_ff == E_IDLE || done);

  always_comb
  begin
    nxt_st = st_ff;
    if (go_new)
      nxt_st = is_read ? E_ACCESS : E_SETUP;
    else if (last)
    begin
      unique case (st_ff)
        E_IDLE: nxt_st = E_IDLE;
        E_SETUP: nxt_st = E_STROBE;
        E_STROBE: nxt_st = E_HOLD;
        E_HOLD: nxt_st = E_IDLE;
        E_ACCESS: nxt_st = E_IDLE;
      endcase
    end
  end

  assign nxt_cnt = (go_new || nxt_st != st_ff) ? 9'h000 : 9'(cnt_ff + 9'h001);

  // state and counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_ff <= E_IDLE;
      cnt_ff <= 9'h000;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= (nxt_st == E_IDLE) ? 9'h000 : nxt_cnt;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  // controls follow the next phase so they change right after the edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ce_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      doe_n_ff <= 1'b1;
    end
    else
    begin
      ce_n_ff <= (nxt_st == E_IDLE);
      oe_n_ff <= (nxt_st != E_ACCESS);
      we_n_ff <= (nxt_st != E_STROBE);
      doe_n_ff <= !(nxt_st == E_SETUP || nxt_st == E_STROBE || nxt_st == E_HOLD);
    end
  end

  // address and data stay put for the whole cycle, so the rising write edge latches them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      addr_ff <= 20'h00000;
      dout_ff <= 8'h00;
    end
    else if (go_new)
    begin
      addr_ff <= addr;
      dout_ff <= wdata;
    end
  end

  // the bus pins are asynchronous to us; only the second stage is looked at
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      din_meta_ff <= 8'h00;
      din_sync_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end
    else
    begin
      din_meta_ff <= data_pins_in;
      din_sync_ff <= din_meta_ff;
      if (done && st_ff == E_ACCESS)
        rdata_ff <= din_sync_ff;
    end
  end

  assign flash_addr = addr_ff;
  assign flash_ce_n = ce_n_ff;
  assign flash_oe_n = oe_n_ff;
  assign flash_we_n = we_n_ff;
  assign data_pins_out = dout_ff;
  assign data_pins_oe_n = doe_n_ff;
  assign rdata = rdata_ff;

  // ****************************************
  // checks
  // ****************************************
  localparam int PULSE_LEN = int'(flash_host_pkg::CYC_WE_PULSE);
  localparam int MAX_CYC = 60;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_read_pins: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && data_pins_oe_n)
    else $error("read strobe without proper select or with bus driven");
  a_we_width: assert property ($fell(flash_we_n) |-> ##PULSE_LEN $rose(flash_we_n))
    else $error("write strobe width wrong");
  a_we_under_ce: assert property (!flash_we_n |-> !flash_ce_n && !data_pins_oe_n && flash_oe_n)
    else $error("write strobe outside select or without data");
  a_cycle_bound: assert property (go_new |=> ##[1:MAX_CYC] done)
    else $error("bus cycle did not finish");

endmodule : flash_bus_cycle
`default_nettype wire

/* File: verilog/flash_host_ctrl.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic power_down_n,
  output logic program_supply_en,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe_n,
  input wire logic [7:0] data_pins_in,
  input wire logic ready_busy_n
);

  typedef enum logic [1:0] {M_IDLE, M_FIRST, M_SECOND} seq_state_t;

  seq_state_t st_ff;
  seq_state_t nxt_st;
  logic pd_ff;
  logic supply_ff;
  logic [3:0] op_ff;
  logic [19:0] addr_ff;
  logic [7:0] wdata_ff;
  logic done_ff;
  logic refused_ff;
  logic [8:0] wake_cnt_ff;
  logic rb_meta_ff;
  logic rb_sync_ff;
  logic [31:0] prdata_ff;

  // ****************************************
  // register decode
  // ****************************************
  logic apb_setup;
  logic apb_wr;
  logic sel_cfg;
  logic sel_cmd;
  logic sel_addr;
  logic sel_wdata;
  logic sel_rdata;
  logic sel_status;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [3:0] cmd_op;
  logic cmd_wr;
  logic awake;
  logic accept;
  logic refuse;
  logic seq_end;
  logic eng_start;
  logic eng_read;
  logic [7:0] eng_wdata;
  logic eng_done;
  logic [7:0] eng_rdata;
  logic idle;

  // zero-wait slave: every access phase completes at once
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign sel_cfg = (paddr == flash_host_pkg::OFS_CONFIG);
  assign sel_cmd = (paddr == flash_host_pkg::OFS_COMMAND);
  assign sel_addr = (paddr == flash_host_pkg::OFS_ADDR);
  assign sel_wdata = (paddr == flash_host_pkg::OFS_WDATA);
  assign sel_rdata = (paddr == flash_host_pkg::OFS_RDATA);
  assign sel_status = (paddr == flash_host_pkg::OFS_STATUS);
  assign mapped = sel_cfg || sel_cmd || sel_addr || sel_wdata || sel_rdata || sel_status;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;

  assign status_word = {27'h0000000, refused_ff, done_ff, awake, rb_sync_ff, !idle};
  assign rd_mux = sel_cfg ? {30'h00000000, supply_ff, pd_ff} :
                  sel_cmd ? {28'h0000000, op_ff} :
                  sel_addr ? {12'h000, addr_ff} :
                  sel_wdata ? {24'h000000, wdata_ff} :
                  sel_rdata ? {24'h000000, eng_rdata} :
                  sel_status ? status_word : 32'h00000000;

  // read data is taken in the setup cycle so it is a flop by the access phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prdata_ff <= 32'h00000000;
    else if (apb_setup)
      prdata_ff <= rd_mux;
  end

  // ****************************************
  // command acceptance
  // ****************************************
  // a command is refused while a sequence runs, before wake-up or in power-down
  assign idle = (st_ff == M_IDLE);
  assign cmd_op = pwdata[3:0];
  assign cmd_wr = apb_wr && sel_cmd;
  assign awake = (wake_cnt_ff == flash_host_pkg::CYC_WAKE_WRITE);
  assign accept = cmd_wr && idle && awake && !pd_ff && flash_host_pkg::op_legal(cmd_op);
  assign refuse = cmd_wr && !accept;

  // first cycle writes the command code, second writes confirm or data, or reads
  assign eng_start = accept ||
    (st_ff == M_FIRST && eng_done && flash_host_pkg::second_kind(op_ff) != flash_host_pkg::KIND_NONE);
  assign eng_read = idle ? !flash_host_pkg::needs_cmd(cmd_op) :
                    (flash_host_pkg::second_kind(op_ff) == flash_host_pkg::KIND_READ);
  assign eng_wdata = idle ? flash_host_pkg::first_code(cmd_op) :
                     flash_host_pkg::second_data(op_ff, wdata_ff);
  assign seq_end = eng_done &&
    (st_ff == M_SECOND ||
     (st_ff == M_FIRST && flash_host_pkg::second_kind(op_ff) == flash_host_pkg::KIND_NONE));

  // sequence state
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      M_IDLE:
        if (accept)
          nxt_st = flash_host_pkg::needs_cmd(cmd_op) ? M_FIRST : M_SECOND;
      M_FIRST:
        if (eng_done)
          nxt_st = seq_end ? M_IDLE : M_SECOND;
      M_SECOND:
        if (eng_done)
          nxt_st = M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_ff <= M_IDLE;
      op_ff <= flash_host_pkg::OP_READ_ARRAY;
    end
    else
    begin
      st_ff <= nxt_st;
      if (accept)
        op_ff <= cmd_op;
    end
  end

  // ****************************************
  // configuration and operands
  // ****************************************
  // operands are frozen while a sequence runs so both cycles see the same block
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pd_ff <= flash_host_pkg::RST_PD;
      supply_ff <= flash_host_pkg::RST_SUPPLY;
      addr_ff <= flash_host_pkg::RST_ADDR;
      wdata_ff <= flash_host_pkg::RST_WDATA;
    end
    else
    begin
      if (apb_wr && sel_cfg)
      begin
        pd_ff <= pwdata[flash_host_pkg::CFG_PD_BIT];
        supply_ff <= pwdata[flash_host_pkg::CFG_SUPPLY_BIT];
      end
      if (apb_wr && sel_addr && idle)
        addr_ff <= pwdata[19:0];
      if (apb_wr && sel_wdata && idle)
        wdata_ff <= pwdata[7:0];
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
    end
    else
    begin
      done_ff <= seq_end || (done_ff && !(apb_wr && sel_status && pwdata[flash_host_pkg::ST_DONE_BIT]));
      refused_ff <= refuse || (refused_ff && !(apb_wr && sel_status && pwdata[flash_host_pkg::ST_REFUSED_BIT]));
    end
  end

  // wake timer: restarts in power-down and after reset, since the part may just have powered up
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wake_cnt_ff <= 9'h000;
    else if (pd_ff)
      wake_cnt_ff <= 9'h000;
    else if (!awake)
      wake_cnt_ff <= 9'(wake_cnt_ff + 9'h001);
  end

  // ready/busy comes from the part, so two stages before use
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rb_meta_ff <= 1'b1;
      rb_sync_ff <= 1'b1;
    end
    else
    begin
      rb_meta_ff <= ready_busy_n;
      rb_sync_ff <= rb_meta_ff;
    end
  end

  assign power_down_n = !pd_ff;
  assign program_supply_en = supply_ff;

  // ****************************************
  // pin cycle engine
  // ****************************************
  flash_bus_cycle u_cycle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(eng_start),
    .is_read(eng_read),
    .addr(addr_ff),
    .wdata(eng_wdata),
    .done(eng_done),
    .rdata(eng_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n),
    .data_pins_in(data_pins_in)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_erase_confirm: assert property (st_ff == M_FIRST && op_ff == flash_host_pkg::OP_ERASE && eng_done
    |-> eng_start && eng_wdata == flash_host_pkg::CMD_CONFIRM && !eng_read)
    else $error("erase confirm not issued after setup");
  a_write_pair: assert property ((st_ff == M_FIRST && eng_done &&
    (op_ff == flash_host_pkg::OP_BYTE_WRITE || op_ff == flash_host_pkg::OP_ALT_WRITE))
    |-> eng_start && eng_wdata == wdata_ff ##1 st_ff == M_SECOND)
    else $error("byte write data cycle missing");
  a_mode_code: assert property (accept && cmd_op == flash_host_pkg::OP_READ_STATUS
    |-> eng_wdata == flash_host_pkg::CMD_READ_STATUS ##1 st_ff == M_FIRST)
    else $error("status read mode code wrong");
  a_suspend_code: assert property (accept && cmd_op == flash_host_pkg::OP_SUSPEND
    |-> eng_wdata == flash_host_pkg::CMD_SUSPEND && !eng_read)
    else $error("suspend code wrong");
  a_awake_start: assert property (accept |-> wake_cnt_ff == flash_host_pkg::CYC_WAKE_WRITE && power_down_n)
    else $error("command started before wake delay");
  a_pd_blocks: assert property ($rose(power_down_n) |-> !accept [*8])
    else $error("command accepted right after power-down release");

  c_erase: cover property (st_ff == M_SECOND && op_ff == flash_host_pkg::OP_ERASE && eng_done);
  c_id_read: cover property (st_ff == M_SECOND && op_ff == flash_host_pkg::OP_READ_ID && eng_done);
  c_byte_write: cover property (st_ff == M_SECOND && op_ff == flash_host_pkg::OP_BYTE_WRITE && eng_done);
  c_refused: cover property (refuse);

endmodule : flash_host_ctrl
`default_nettype wire

/* File: verification/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// behavioural flash device on the far side of the pins
// ****
module flash_dev_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary value
  parameter int WR_CYC = 40,
  parameter int ER_CYC = 150
) (
  input wire logic core_clk,
  input wire logic [19:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic power_down_n,
  input wire logic program_supply_en,
  input wire logic [7:0] host_data,
  input wire logic host_oe_n,
  output logic [7:0] pins,
  output logic ready_busy_n
);
  logic [7:0] mem [logic [19:0]];
  logic [1:0] mode = 2'h0; // 0 array, 1 id, 2 status
  logic [7:0] pend = 8'h00;
  logic [5:0] sr = 6'h00;
  logic [7:0] last = 8'h00;
  logic susp = 1'b0;
  logic we_q = 1'b1;
  int busy = 0;
  logic [7:0] dout;
  logic drv;
  logic run;

  function automatic logic [7:0] arr(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : arr

  // a released bus shows the inverse of its last level, never a kind guess
  assign run = busy != 0 && !susp;
  assign drv = !flash_ce_n && !flash_oe_n && power_down_n;
  assign pins = !host_oe_n ? host_data : drv ? dout : ~last;
  assign ready_busy_n = !run || !power_down_n;

  // read source follows the last command, at either supply level
  always @*
  begin
    case (mode)
      2'h1: dout = flash_addr[0] ? DEV_CODE : MFR_CODE;
      2'h2: dout = {!run, susp, sr};
      default: dout = arr(flash_addr);
    endcase
  end

  task automatic take(input logic [19:0] a, input logic [7:0] d);
    pend <= 8'h00;
    if (pend != 8'h00)
    begin
      mode <= 2'h2;
      if (!program_supply_en)
        sr <= sr | (pend == 8'h20 ? 6'h28 : 6'h18);
      else if (pend != 8'h20)
      begin
        mem[a] = d;
        busy <= WR_CYC;
      end
      else if (d == 8'hD0)
      begin
        foreach (mem[k])
          if (k[19:16] == a[19:16])
            mem[k] = 8'hFF;
        busy <= ER_CYC;
      end
    end
    else
      case (d)
        8'hFF: if (busy == 0) mode <= 2'h0;
        8'h90: mode <= 2'h1;
        8'h70: mode <= 2'h2;
        8'h50: sr <= 6'h00;
        8'h20, 8'h40, 8'h10: if (busy == 0) pend <= d;
        8'hB0: susp <= busy != 0;
        8'hD0: susp <= 1'b0;
        default: ; // reserved codes change nothing
      endcase
  endtask : take

  // commands land when write enable rises with the chip selected
  always @(posedge core_clk)
  begin
    we_q <= flash_we_n;
    if (!host_oe_n || drv)
      last <= pins;
    if (run)
      busy <= busy - 1; // runs on while deselected
    if (!power_down_n)
    begin
      mode <= 2'h0;
      sr <= 6'h00;
      busy <= 0;
      pend <= 8'h00;
      susp <= 1'b0;
    end
    else if (flash_we_n && !we_q && !flash_ce_n)
      take(flash_addr, host_data);
  end
endmodule : flash_dev_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// self-checking bench for the flash host controller
// ****
module tb_top;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [19:0] flash_addr;
  logic flash_ce_n;
  logic flash_oe_n;
  logic flash_we_n;
  logic power_down_n;
  logic program_supply_en;
  logic [7:0] data_pins_out;
  logic data_pins_oe_n;
  logic [7:0] data_pins_in;
  logic ready_busy_n;
  logic err_q;
  logic [31:0] r;
  int failures = 0;
  int num_checks = 0;
  int bad = 0;

  flash_host_ctrl u_flash_host_ctrl (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .power_down_n, .program_supply_en,
    .data_pins_out, .data_pins_oe_n, .data_pins_in, .ready_busy_n);

  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash_dev_model (.core_clk, .flash_addr, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .power_down_n, .program_supply_en, .host_data(data_pins_out),
    .host_oe_n(data_pins_oe_n), .pins(data_pins_in), .ready_busy_n);

  initial forever #2 core_clk = ~core_clk;

  // a write strobe outside a selected cycle, or both sides driving, is a fault
  always @(posedge core_clk)
  begin
    if (rst_n && ((!flash_we_n && flash_ce_n) || (!flash_oe_n && !data_pins_oe_n)))
      bad++;
  end

  task automatic give_verdict;
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // no cycle count is assumed here; only the watchdog ends a stuck wait
    while (pready !== 1'b1)
      @(posedge core_clk);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // polling is bounded so a stuck flag ends as a mismatch, not a hang
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      rd(flash_host_pkg::OFS_STATUS);
      n++;
    end
    while ((r & m) !== v && n < 400);
    chk(r & m, v);
  endtask : poll

  // m = 1 waits for the host engine, m = 3 for the device as well
  task automatic op(input logic [3:0] o, input logic [31:0] m);
    wr(flash_host_pkg::OFS_COMMAND, {28'h0, o});
    poll(m, 32'h2 & m);
  endtask : op

  task automatic rd_at(input logic [19:0] a, input logic [3:0] o);
    wr(flash_host_pkg::OFS_ADDR, {12'h0, a});
    op(o, 32'h1);
    rd(flash_host_pkg::OFS_RDATA);
  endtask : rd_at

  initial
  begin
    logic [19:0] a;
    logic [7:0] d;
    int i;
    void'($urandom(59));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(flash_host_pkg::OFS_CONFIG);
    chk(r, 32'h0);
    wr(flash_host_pkg::OFS_COMMAND, 32'h1);
    poll(32'h14, 32'h10);
    poll(32'h4, 32'h4);
    wr(flash_host_pkg::OFS_STATUS, 32'h18);
    rd(8'h40);
    chk({err_q, r[30:0]}, 32'h80000000);
    wr(flash_host_pkg::OFS_CONFIG, 32'h2);
    for (i = 0; i < 2; i++)
    begin
      rd_at(i[19:0], 4'h1);
      chk(r, {24'h0, i[0] ? DEV : MFR});
    end
    for (i = 0; i < 6; i++)
    begin
      a = 20'($urandom);
      d = 8'($urandom);
      wr(flash_host_pkg::OFS_ADDR, {12'h0, a});
      wr(flash_host_pkg::OFS_WDATA, {24'h0, d});
      op(i[0] ? 4'h8 : 4'h7, 32'h3);
      rd_at(a, 4'h2);
      chk(r, 32'h80);
      op(4'h0, 32'h3);
      rd_at(a, 4'h9);
      chk(r, {24'h0, d});
    end
    wr(flash_host_pkg::OFS_CONFIG, 32'h0);
    wr(flash_host_pkg::OFS_WDATA, {24'h0, ~d});
    op(4'h7, 32'h3);
    rd_at(a, 4'h2);
    chk(r, 32'h98);
    op(4'h3, 32'h3);
    rd_at(a, 4'h2);
    chk(r, 32'h80);
    op(4'h0, 32'h3);
    rd_at(a, 4'h9);
    chk(r, {24'h0, d});
    wr(flash_host_pkg::OFS_COMMAND, 32'hF);
    poll(32'h10, 32'h10);
    wr(flash_host_pkg::OFS_STATUS, 32'h18);
    wr(flash_host_pkg::OFS_CONFIG, 32'h2);
    op(4'h4, 32'h1);
    op(4'h0, 32'h1);
    rd_at(a, 4'h9);
    chk(r, 32'h0);
    op(4'h5, 32'h1);
    poll(32'h2, 32'h2);
    op(4'h6, 32'h3);
    op(4'h0, 32'h3);
    rd_at(a, 4'h9);
    chk(r, 32'hFF);
    op(4'h4, 32'h1);
    wr(flash_host_pkg::OFS_CONFIG, 32'h3);
    chk({31'h0, power_down_n}, 32'h0);
    poll(32'h2, 32'h2);
    wr(flash_host_pkg::OFS_CONFIG, 32'h2);
    poll(32'h4, 32'h4);
    rd_at(a, 4'h9);
    chk(r, 32'hFF);
    rd_at(a, 4'h2);
    chk(r, 32'h80);
    chk(32'(bad), 32'h0);
    give_verdict();
  end

  // the whole run needs a few thousand cycles; this is far beyond that
  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
